/* File: shared/phy_irq_pkg.sv */
// Constants shared by the management interrupt logic and its serial port
package phy_irq_pkg;

	// ****************************************************************
	// Register addresses on the serial management port
	// ****************************************************************
	localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
	localparam logic [4:0] REG_AN_EXPANSION = 5'h06;
	localparam logic [4:0] REG_MODE_CTRL    = 5'h11;
	localparam logic [4:0] REG_IRQ_FLAGS    = 5'h1d;
	localparam logic [4:0] REG_IRQ_MASK     = 5'h1e;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int          ALT_SEL_BIT     = 6;
	localparam int          ENERGY_BIT      = 1;
	localparam int          SRC_ENERGY      = 7;
	localparam int          SRC_AN_DONE     = 6;
	localparam int          SRC_REMOTE      = 5;
	localparam int          SRC_LINK_DOWN   = 4;
	localparam int          SRC_LP_ACK      = 3;
	localparam int          SRC_PAR_FAULT   = 2;
	localparam int          SRC_PAGE_RX     = 1;
	localparam logic [7:0]  SRC_USED        = 8'hfe;
	localparam logic [7:0]  FLAGS_RST       = 8'h80;
	localparam logic [7:0]  MASK_RST        = 8'h00;
	localparam logic [7:0]  ACTIVE_PREV_RST = 8'h10;
	localparam logic        ALT_SEL_RST     = 1'b0;

	// ****************************************************************
	// Management frame layout
	// ****************************************************************
	localparam int          PREAMBLE_BITS = 32;
	localparam int          HDR_BITS      = 13;
	localparam int          DATA_BITS     = 16;
	localparam logic [1:0]  OP_READ       = 2'h2;
	localparam logic [1:0]  OP_WRITE      = 2'h1;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_KHZ             = 125000;
	localparam int unsigned ENERGY_DELAY_MS     = 1000;
	localparam int unsigned ENERGY_PULSE_MS     = 256;
	localparam int unsigned ENERGY_DELAY_CYCLES = ENERGY_DELAY_MS * CLK_KHZ;
	localparam int unsigned ENERGY_PULSE_CYCLES = ENERGY_PULSE_MS * CLK_KHZ;

endpackage

/* File: hdl/mgmt_serial_port.sv */
// Serial management port slave: frame decode, register strobes, read shift-out
`timescale 1ns/100ps
module mgmt_serial_port (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe,
	input  wire logic [4:0]  phy_addr,
	input  wire logic [15:0] rd_data,
	output logic [4:0]       reg_addr,
	output logic             rd_stb,
	output logic             wr_stb,
	output logic [15:0]      wr_data
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_HDR   = 3'h1,
		ST_TA    = 3'h2,
		ST_WDATA = 3'h3,
		ST_RDATA = 3'h4
	} port_state_t;

	port_state_t  st;
	logic [2:0]   mdc_sync;
	logic [2:0]   mdio_sync;
	logic         mdc_lvl;
	logic         mdc_rise;
	logic         bit_in;
	logic [5:0]   ones;
	logic [4:0]   cnt;
	logic [11:0]  sr;
	logic [12:0]  hdr;
	logic [15:0]  out_sr;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mdc_sync  <= 3'h0;
			mdio_sync <= 3'h0;
		end else begin
			mdc_sync  <= {mdc_sync[1:0], mdc};
			mdio_sync <= {mdio_sync[1:0], mdio_in};
		end
	end

	// Clock level only moves once the last two stages agree
	always_ff @(posedge ref_clk) begin
		if (rst)
			mdc_lvl <= 1'b0;
		else if (mdc_sync[2] == mdc_sync[1])
			mdc_lvl <= mdc_sync[1];
	end

	assign mdc_rise = (mdc_sync[2] == mdc_sync[1]) && mdc_sync[1] && !mdc_lvl;
	assign bit_in   = mdio_sync[2];
	assign hdr      = {sr, bit_in};

	// ****************************************************************
	// Frame decode
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st       <= ST_IDLE;
			ones     <= 6'h00;
			cnt      <= 5'h00;
			sr       <= 12'h000;
			reg_addr <= 5'h00;
			rd_stb   <= 1'b0;
			wr_stb   <= 1'b0;
			wr_data  <= 16'h0000;
		end else begin
			rd_stb <= 1'b0;
			wr_stb <= 1'b0;
			if (mdc_rise) begin
				unique case (st)
					ST_IDLE: begin
						if (bit_in) begin
							if (ones != 6'(phy_irq_pkg::PREAMBLE_BITS))
								ones <= ones + 6'h01;
						end else begin
							if (ones == 6'(phy_irq_pkg::PREAMBLE_BITS)) begin
								st  <= ST_HDR;
								cnt <= 5'h00;
							end
							ones <= 6'h00;
						end
					end
					ST_HDR: begin
						sr  <= hdr[11:0];
						cnt <= cnt + 5'h01;
						if (cnt == 5'(phy_irq_pkg::HDR_BITS - 1)) begin
							cnt      <= 5'h00;
							reg_addr <= hdr[4:0];
							st       <= ST_IDLE;
							// Frames for other addresses are ignored silently
							if (hdr[12] && hdr[9:5] == phy_addr) begin
								if (hdr[11:10] == phy_irq_pkg::OP_READ) begin
									st     <= ST_RDATA;
									rd_stb <= 1'b1;
								end else if (hdr[11:10] == phy_irq_pkg::OP_WRITE) begin
									st <= ST_TA;
								end
							end
						end
					end
					ST_TA: begin
						cnt <= cnt + 5'h01;
						if (cnt == 5'h01) begin
							cnt <= 5'h00;
							st  <= ST_WDATA;
						end
					end
					ST_WDATA: begin
						wr_data <= {wr_data[14:0], bit_in};
						cnt     <= cnt + 5'h01;
						if (cnt == 5'(phy_irq_pkg::DATA_BITS - 1)) begin
							wr_stb <= 1'b1;
							st     <= ST_IDLE;
						end
					end
					ST_RDATA: begin
						cnt <= cnt + 5'h01;
						if (cnt == 5'(phy_irq_pkg::DATA_BITS + 1))
							st <= ST_IDLE;
					end
					default: st <= ST_IDLE;
				endcase
			end
		end
	end

	// ****************************************************************
	// Read data drive
	// ****************************************************************
	// Snapshot taken with the strobe, before any read-clear lands
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			out_sr   <= 16'h0000;
			mdio_out <= 1'b0;
			mdio_oe  <= 1'b0;
		end else if (rd_stb) begin
			out_sr <= rd_data;
		end else if (mdc_rise && st == ST_RDATA) begin
			if (cnt == 5'h00) begin
				mdio_oe  <= 1'b1;
				mdio_out <= 1'b0;
			end else if (cnt <= 5'(phy_irq_pkg::DATA_BITS)) begin
				mdio_out <= out_sr[15];
				out_sr   <= {out_sr[14:0], 1'b0};
			end else begin
				mdio_oe  <= 1'b0;
				mdio_out <= 1'b0;
			end
		end
	end

endmodule

/* File: hdl/phy_mgmt_interrupt_logic.sv */
// Interrupt flags, mask, release modes and interrupt pin of the management block
`timescale 1ns/100ps
module phy_mgmt_interrupt_logic #(
	parameter int unsigned DELAY_CYCLES = phy_irq_pkg::ENERGY_DELAY_CYCLES,
	parameter int unsigned PULSE_CYCLES = phy_irq_pkg::ENERGY_PULSE_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe,
	input  wire logic [4:0]  phy_addr,
	input  wire logic        energy_detect,
	input  wire logic        an_complete,
	input  wire logic        remote_fault,
	input  wire logic        link_status,
	input  wire logic        lp_ack,
	input  wire logic        par_det_fault,
	input  wire logic        page_received,
	input  wire logic        an_restart,
	input  wire logic [15:0] other_rd_data,
	output logic [4:0]       reg_addr,
	output logic             rd_stb,
	output logic             wr_stb,
	output logic [15:0]      wr_data,
	output logic             alt_release_sel,
	output logic             irq_out_n
);
	typedef enum logic [1:0] {
		EN_IDLE  = 2'h0,
		EN_ARMED = 2'h1,
		EN_WAIT  = 2'h2,
		EN_PULSE = 2'h3
	} energy_state_t;

	logic [15:0]   rd_data;
	logic [7:0]    active;
	logic [7:0]    active_prev;
	logic [7:0]    assert_evt;
	logic [7:0]    fall_evt;
	logic [7:0]    flags;
	logic [7:0]    mask;
	logic [7:0]    next_flags;
	logic          rd_flags;
	logic          rd_status;
	logic          rd_expansion;
	logic          wr_flags;
	logic          link_loss;
	logic          energy_released;
	energy_state_t en_st;
	logic [31:0]   en_cnt;

	// ****************************************************************
	// Management port
	// ****************************************************************
	mgmt_serial_port u_port (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.mdc      (mdc),
		.mdio_in  (mdio_in),
		.mdio_out (mdio_out),
		.mdio_oe  (mdio_oe),
		.phy_addr (phy_addr),
		.rd_data  (rd_data),
		.reg_addr (reg_addr),
		.rd_stb   (rd_stb),
		.wr_stb   (wr_stb),
		.wr_data  (wr_data)
	);

	assign rd_flags     = rd_stb && reg_addr == phy_irq_pkg::REG_IRQ_FLAGS;
	assign rd_status    = rd_stb && reg_addr == phy_irq_pkg::REG_BASIC_STATUS;
	assign rd_expansion = rd_stb && reg_addr == phy_irq_pkg::REG_AN_EXPANSION;
	assign wr_flags     = wr_stb && reg_addr == phy_irq_pkg::REG_IRQ_FLAGS;

	// Other registers belong to the rest of the management logic
	always_comb begin
		rd_data = other_rd_data;
		unique case (reg_addr)
			phy_irq_pkg::REG_IRQ_FLAGS: rd_data = {8'h00, flags};
			phy_irq_pkg::REG_IRQ_MASK:  rd_data = {8'h00, mask};
			phy_irq_pkg::REG_MODE_CTRL: begin
				rd_data[phy_irq_pkg::ALT_SEL_BIT] = alt_release_sel;
				rd_data[phy_irq_pkg::ENERGY_BIT]  = energy_detect;
			end
			default: rd_data = other_rd_data;
		endcase
	end

	// ****************************************************************
	// Mode and mask registers
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst)
			alt_release_sel <= phy_irq_pkg::ALT_SEL_RST;
		else if (wr_stb && reg_addr == phy_irq_pkg::REG_MODE_CTRL)
			alt_release_sel <= wr_data[phy_irq_pkg::ALT_SEL_BIT];
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			mask <= phy_irq_pkg::MASK_RST;
		else if (wr_stb && reg_addr == phy_irq_pkg::REG_IRQ_MASK)
			mask <= wr_data[7:0] & phy_irq_pkg::SRC_USED;
	end

	// ****************************************************************
	// Source events
	// ****************************************************************
	// Link-down is active while the link is low, so one edge rule serves all
	always_comb begin
		active                            = 8'h00;
		active[phy_irq_pkg::SRC_ENERGY]    = energy_detect;
		active[phy_irq_pkg::SRC_AN_DONE]   = an_complete;
		active[phy_irq_pkg::SRC_REMOTE]    = remote_fault;
		active[phy_irq_pkg::SRC_LINK_DOWN] = !link_status;
		active[phy_irq_pkg::SRC_LP_ACK]    = lp_ack;
		active[phy_irq_pkg::SRC_PAR_FAULT] = par_det_fault;
		active[phy_irq_pkg::SRC_PAGE_RX]   = page_received;
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			active_prev <= phy_irq_pkg::ACTIVE_PREV_RST;
		else
			active_prev <= active;
	end

	assign assert_evt = active & ~active_prev;
	assign fall_evt   = ~active & active_prev;
	assign link_loss  = assert_evt[phy_irq_pkg::SRC_LINK_DOWN];

	// ****************************************************************
	// Source flags
	// ****************************************************************
	assign next_flags[0] = 1'b0;
	for (genvar i = 1; i < 8; i++) begin : g_flag
		logic rel_primary;
		logic rel_alt;
		always_comb begin
			rel_primary = rd_flags;
			if (i != phy_irq_pkg::SRC_LINK_DOWN)
				rel_primary = rel_primary || fall_evt[i];
			if (i == phy_irq_pkg::SRC_REMOTE || i == phy_irq_pkg::SRC_LINK_DOWN)
				rel_primary = rel_primary || rd_status;
			if (i == phy_irq_pkg::SRC_PAR_FAULT || i == phy_irq_pkg::SRC_PAGE_RX)
				rel_primary = rel_primary || rd_expansion || an_restart || link_loss;
		end
		// Recheck on write-one: only a released source lets the flag go
		assign rel_alt = wr_flags && wr_data[i] && !active[i];
		// Setting beats any release landing in the same cycle
		assign next_flags[i] = assert_evt[i] ? 1'b1 :
			(alt_release_sel ? (flags[i] && !rel_alt) : (flags[i] && !rel_primary));
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			flags <= phy_irq_pkg::FLAGS_RST;
		else
			flags <= next_flags;
	end

	// ****************************************************************
	// Late energy pulse after cable removal
	// ****************************************************************
	assign energy_released = rd_flags && flags[phy_irq_pkg::SRC_ENERGY]
		&& active[phy_irq_pkg::SRC_ENERGY] && !assert_evt[phy_irq_pkg::SRC_ENERGY];

	// Clearing the mask cancels it, which is why service code should do so
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			en_st  <= EN_IDLE;
			en_cnt <= 32'h0000_0000;
		end else if (alt_release_sel || !mask[phy_irq_pkg::SRC_ENERGY]) begin
			en_st  <= EN_IDLE;
			en_cnt <= 32'h0000_0000;
		end else begin
			unique case (en_st)
				EN_IDLE:
					if (energy_released)
						en_st <= EN_ARMED;
				EN_ARMED:
					if (fall_evt[phy_irq_pkg::SRC_ENERGY]) begin
						en_st  <= EN_WAIT;
						en_cnt <= 32'h0000_0000;
					end
				EN_WAIT: begin
					en_cnt <= en_cnt + 32'h0000_0001;
					if (en_cnt == DELAY_CYCLES - 1) begin
						en_st  <= EN_PULSE;
						en_cnt <= 32'h0000_0000;
					end
				end
				EN_PULSE: begin
					en_cnt <= en_cnt + 32'h0000_0001;
					if (en_cnt == PULSE_CYCLES - 1)
						en_st <= EN_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Interrupt pin
	// ****************************************************************
	// Event term bypasses the flag register so the pin needs no clock edge
	assign irq_out_n = !(|(mask & (flags | assert_evt))) && (en_st != EN_PULSE);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	irq_event_a: assert property (
		(mask & assert_evt) != 8'h00 |-> !irq_out_n ##1 (mask & flags) != 8'h00)
		else $error("enabled event did not pull interrupt low");

	mode_reset_a: assert property (
		@(posedge ref_clk) $past(rst) |-> !alt_release_sel)
		else $error("mode not primary after reset");

	mode_write_a: assert property (
		wr_stb && reg_addr == phy_irq_pkg::REG_MODE_CTRL && wr_data[phy_irq_pkg::ALT_SEL_BIT]
		|=> alt_release_sel ##1 alt_release_sel || wr_stb)
		else $error("alternate mode not taken");

	flag_read_a: assert property (
		!alt_release_sel && rd_flags && assert_evt == 8'h00 |=> flags == 8'h00)
		else $error("flag read did not release all sources");

	status_read_a: assert property (
		!alt_release_sel && rd_status && assert_evt[5:4] == 2'h0 |=> flags[5:4] == 2'h0)
		else $error("status read did not release fault and link down");

	expansion_read_a: assert property (
		!alt_release_sel && (rd_expansion || an_restart || link_loss)
		&& assert_evt[2:1] == 2'h0 |=> flags[2:1] == 2'h0)
		else $error("page or fault flag survived its release");

	primary_fall_a: assert property (
		!alt_release_sel && fall_evt[phy_irq_pkg::SRC_AN_DONE]
		|=> !flags[phy_irq_pkg::SRC_AN_DONE])
		else $error("falling source did not release its flag");

	alt_hold_a: assert property (
		alt_release_sel && wr_flags && flags[phy_irq_pkg::SRC_AN_DONE]
		&& active[phy_irq_pkg::SRC_AN_DONE] |=> flags[phy_irq_pkg::SRC_AN_DONE])
		else $error("flag cleared while source still active");

	alt_clear_a: assert property (
		alt_release_sel && wr_flags && wr_data[phy_irq_pkg::SRC_AN_DONE]
		&& !active[phy_irq_pkg::SRC_AN_DONE] |=> !flags[phy_irq_pkg::SRC_AN_DONE])
		else $error("write one did not clear released source");

	mask_gate_a: assert property (
		(mask & (flags | assert_evt)) == 8'h00 && en_st != EN_PULSE |-> irq_out_n)
		else $error("interrupt low with nothing enabled");

	energy_pulse_a: assert property (
		en_st == EN_WAIT && en_cnt == DELAY_CYCLES - 1 && mask[7] && !alt_release_sel
		|=> !irq_out_n)
		else $error("energy removal pulse missing");

endmodule

/* File: verif/mgmt_station_model.sv */
// Station management controller model for the two-wire management port
`timescale 1ns/100ps
module mgmt_station_model #(
	parameter logic [4:0] PHY_ADDR = 5'h00
) (
	input  wire logic ref_clk,
	input  wire logic mdio_out,
	input  wire logic mdio_oe,
	output logic      mdc,
	output logic      mdio_in
);
	logic drv_en   = 1'b0;
	logic drv_bit  = 1'b0;
	int   half_cyc = 25;

	// Line has a pull-up, so a released line reads high
	assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_bit : 1'b1);

	initial mdc = 1'b0;

	// ****************************************************************
	// Bit and frame sequencing
	// ****************************************************************
	// Data changes with the clock low and holds past the rise
	task automatic send_bit(input logic b, input logic en, output logic smp);
		@(posedge ref_clk);
		mdc <= 1'b0;
		drv_en <= en;
		drv_bit <= b;
		repeat (half_cyc) @(posedge ref_clk);
		mdc <= 1'b1;
		smp = mdio_in;
		repeat (half_cyc - 1) @(posedge ref_clk);
	endtask

	task automatic frame(input logic [1:0] op, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hdr;
		logic [17:0] tail;
		logic        s;
		hdr = {32'hffffffff, 2'b01, op, PHY_ADDR, ra};
		tail = {2'b10, wd};
		rd = 16'h0000;
		for (int i = 45; i >= 0; i--) begin
			send_bit(hdr[i], 1'b1, s);
		end
		// Reads release the line for turnaround and data
		for (int i = 17; i >= 0; i--) begin
			send_bit(tail[i], op == phy_irq_pkg::OP_WRITE, s);
			if (i < 16) begin
				rd[i] = s;
			end
		end
		@(posedge ref_clk);
		mdc <= 1'b0;
		drv_en <= 1'b0;
		// Clock stands still between frames
		repeat (8) @(posedge ref_clk);
	endtask

	task automatic rd(input logic [4:0] ra, output logic [15:0] d);
		frame(phy_irq_pkg::OP_READ, ra, 16'h0000, d);
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
		logic [15:0] d;
		frame(phy_irq_pkg::OP_WRITE, ra, wd, d);
	endtask
endmodule

/* File: verif/phy_mgmt_interrupt_logic_tb_top.sv */
// Self-checking bench for the management interrupt logic
`timescale 1ns/100ps
module phy_mgmt_interrupt_logic_tb_top;
	localparam int          DLY   = 40;
	localparam int          PLS   = 20;
	localparam int          LIMIT = 100000;
	localparam logic [4:0]  PADDR = 5'h05;
	localparam logic [15:0] OTHER = 16'ha5e7;
	localparam logic [4:0]  FLG   = phy_irq_pkg::REG_IRQ_FLAGS;
	localparam logic [4:0]  MSK   = phy_irq_pkg::REG_IRQ_MASK;

	logic        ref_clk       = 1'b0;
	logic        rst           = 1'b1;
	logic        energy_detect = 1'b0;
	logic        an_complete   = 1'b0;
	logic        remote_fault  = 1'b0;
	logic        link_status   = 1'b1;
	logic        lp_ack        = 1'b0;
	logic        par_det_fault = 1'b0;
	logic        page_received = 1'b0;
	logic        an_restart    = 1'b0;
	logic        mdc;
	logic        mdio_in;
	logic        mdio_out;
	logic        mdio_oe;
	logic        alt_release_sel;
	logic        irq_out_n;
	logic [15:0] rdv;
	logic [4:0]  reg_addr;
	logic        rd_stb;
	logic        wr_stb;
	logic [15:0] wr_data;
	int          n_stb         = 0;
	int          error_cnt     = 0;
	int          n_checks      = 0;
	int          cycles        = 0;

	always #4 ref_clk = ~ref_clk;

	phy_mgmt_interrupt_logic #(.DELAY_CYCLES(DLY), .PULSE_CYCLES(PLS)) i_phy_mgmt_interrupt_logic (
		.ref_clk(ref_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .phy_addr(PADDR), .energy_detect(energy_detect),
		.an_complete(an_complete), .remote_fault(remote_fault), .link_status(link_status),
		.lp_ack(lp_ack), .par_det_fault(par_det_fault), .page_received(page_received),
		.an_restart(an_restart), .other_rd_data(OTHER), .reg_addr(reg_addr), .rd_stb(rd_stb),
		.wr_stb(wr_stb), .wr_data(wr_data), .alt_release_sel(alt_release_sel),
		.irq_out_n(irq_out_n)
	);

	mgmt_station_model #(.PHY_ADDR(PADDR)) i_mgmt_station_model (
		.ref_clk(ref_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in)
	);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Link down is active while link_status is low
	task automatic set_src(input int i, input logic v);
		@(posedge ref_clk);
		case (i)
			7: energy_detect <= v;
			6: an_complete <= v;
			5: remote_fault <= v;
			4: link_status <= ~v;
			3: lp_ack <= v;
			2: par_det_fault <= v;
			default: page_received <= v;
		endcase
	endtask

	task automatic stop_test();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (rd_stb || wr_stb)
			n_stb <= n_stb + 1;
		if (cycles == LIMIT) begin
			error_cnt++;
			stop_test();
		end
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		chk_pin(alt_release_sel, 1'b0);
		chk_pin(irq_out_n, 1'b1);
		i_mgmt_station_model.rd(phy_irq_pkg::REG_MODE_CTRL, rdv);
		chk_reg(rdv, 16'ha5a5);
		i_mgmt_station_model.rd(FLG, rdv);
		chk_reg(rdv, 16'h0080);
		$display("test reset done");
	endtask

	task automatic t_map();
		for (int i = 6; i >= 1; i--) begin
			i_mgmt_station_model.wr(MSK, 16'h0001 << i);
			set_src(i, 1'b1);
			#1 chk_pin(irq_out_n, 1'b0);
			i_mgmt_station_model.rd(FLG, rdv);
			chk_reg(rdv, 16'h0001 << i);
			chk_pin(irq_out_n, 1'b1);
			set_src(i, 1'b0);
		end
		set_src(1, 1'b1);
		#1 chk_pin(irq_out_n, 1'b0);
		set_src(1, 1'b0);
		tick(2);
		chk_pin(irq_out_n, 1'b1);
		$display("test map done");
	endtask

	task automatic t_status();
		i_mgmt_station_model.wr(MSK, 16'h0036);
		chk_reg(wr_data, 16'h0036);
		chk_reg(16'(reg_addr), 16'(MSK));
		set_src(3, 1'b1);
		tick(2);
		chk_pin(irq_out_n, 1'b1);
		set_src(5, 1'b1);
		#1 chk_pin(irq_out_n, 1'b0);
		i_mgmt_station_model.rd(phy_irq_pkg::REG_BASIC_STATUS, rdv);
		chk_reg(rdv, OTHER);
		chk_pin(irq_out_n, 1'b1);
		set_src(4, 1'b1);
		#1 chk_pin(irq_out_n, 1'b0);
		i_mgmt_station_model.rd(phy_irq_pkg::REG_BASIC_STATUS, rdv);
		chk_pin(irq_out_n, 1'b1);
		set_src(4, 1'b0);
		set_src(5, 1'b0);
		set_src(3, 1'b0);
		set_src(1, 1'b1);
		#1 chk_pin(irq_out_n, 1'b0);
		@(posedge ref_clk);
		an_restart <= 1'b1;
		@(posedge ref_clk);
		an_restart <= 1'b0;
		tick(2);
		chk_pin(irq_out_n, 1'b1);
		set_src(2, 1'b1);
		#1 chk_pin(irq_out_n, 1'b0);
		i_mgmt_station_model.rd(phy_irq_pkg::REG_AN_EXPANSION, rdv);
		chk_pin(irq_out_n, 1'b1);
		set_src(2, 1'b0);
		i_mgmt_station_model.wr(MSK, 16'h0006);
		set_src(2, 1'b1);
		#1 chk_pin(irq_out_n, 1'b0);
		set_src(4, 1'b1);
		tick(2);
		chk_pin(irq_out_n, 1'b1);
		set_src(4, 1'b0);
		set_src(2, 1'b0);
		set_src(1, 1'b0);
		$display("test status done");
	endtask

	task automatic t_energy();
		int first;
		int lows;
		first = -1;
		lows = 0;
		i_mgmt_station_model.wr(MSK, 16'h0080);
		set_src(7, 1'b1);
		#1 chk_pin(irq_out_n, 1'b0);
		i_mgmt_station_model.rd(FLG, rdv);
		// Link-down flag from the status test waits for a read
		chk_reg(rdv, 16'h0090);
		chk_pin(irq_out_n, 1'b1);
		set_src(7, 1'b0);
		for (int c = 0; c < DLY + PLS + 10; c++) begin
			@(posedge ref_clk);
			#1;
			if (irq_out_n === 1'b0) begin
				if (first < 0) begin
					first = c;
				end
				lows++;
			end
		end
		chk_reg(16'(lows), 16'(PLS));
		chk_pin(first >= DLY - 1 && first <= DLY + 2, 1'b1);
		i_mgmt_station_model.wr(MSK, 16'h0000);
		$display("test energy done");
	endtask

	task automatic t_alt();
		// Slow management clock for one frame
		i_mgmt_station_model.half_cyc = 40;
		i_mgmt_station_model.wr(phy_irq_pkg::REG_MODE_CTRL, 16'h0040);
		i_mgmt_station_model.half_cyc = 25;
		chk_pin(alt_release_sel, 1'b1);
		i_mgmt_station_model.wr(MSK, 16'h0040);
		set_src(6, 1'b1);
		#1 chk_pin(irq_out_n, 1'b0);
		i_mgmt_station_model.wr(FLG, 16'h0040);
		chk_pin(irq_out_n, 1'b0);
		set_src(6, 1'b0);
		tick(2);
		chk_pin(irq_out_n, 1'b0);
		i_mgmt_station_model.wr(FLG, 16'h0040);
		chk_pin(irq_out_n, 1'b1);
		set_src(6, 1'b1);
		#1 chk_pin(irq_out_n, 1'b0);
		i_mgmt_station_model.wr(MSK, 16'h0000);
		chk_pin(irq_out_n, 1'b1);
		set_src(6, 1'b0);
		$display("test alternate done");
	endtask

	initial begin
		tick(8);
		rst <= 1'b0;
		tick(4);
		t_reset();
		t_map();
		t_status();
		t_energy();
		t_alt();
		// One strobe per frame addressed here
		chk_reg(16'(n_stb), 16'h001b);
		stop_test();
	end
endmodule
